// ### core/cmp_event_defs.vh
`ifndef CMP_EVENT_DEFS_VH
`define CMP_EVENT_DEFS_VH

// Register bus geometry
`define CMP_ADDR_W 4
`define CMP_DATA_W 8

// Register offsets
`define CMP_OFS_CTRL 4'h0
`define CMP_OFS_MODE 4'h1
`define CMP_OFS_SRC 4'h2
`define CMP_OFS_EVT_STATUS 4'h3
`define CMP_OFS_EVT_MASK 4'h4

// Control register fields
`define CMP_CTRL_ENABLE 7
`define CMP_CTRL_RESULT 6
`define CMP_CTRL_RISE_FLAG 5
`define CMP_CTRL_FALL_FLAG 4

// Mode register fields
`define CMP_MODE_RISE_IE 5
`define CMP_MODE_FALL_IE 4
`define CMP_MODE_SEL_HI 1
`define CMP_MODE_SEL_LO 0

// Source register field
`define CMP_SRC_ENABLE 0

// Event status and mask fields
`define CMP_EVT_RISE 0
`define CMP_EVT_FALL 1
`define CMP_EVT_NUM 2

// Reset values
`define CMP_RST_ENABLE 1'b0
`define CMP_RST_RISE_IE 1'b0
`define CMP_RST_FALL_IE 1'b0
`define CMP_RST_MODE 2'h0
`define CMP_RST_SRC 1'b0
`define CMP_RST_EVT_MASK 2'h0
`define CMP_RST_RDATA 8'h00
`define CMP_RST_FLAG 1'b0
`define CMP_RST_SHUTDOWN 1'b1
`define CMP_RST_INT 1'b0

// Response time settings
`define CMP_MODE_FASTEST 2'h0
`define CMP_MODE_LOW_POWER 2'h3

`endif

// ### core/cmp_sync2.v
`timescale 1ns/1ps

// Two-stage synchroniser for an asynchronous level
module cmp_sync2
(
  input wire ref_clk,
  input wire srst,
  input wire async_in,
  output reg sync_out
);

  reg meta;

  // First stage is read only by the second stage
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      meta <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end

endmodule

// ### core/cmp_edge_detect.v
`timescale 1ns/1ps

// Edge detector on successive samples of a synchronous level
module cmp_edge_detect
(
  input wire ref_clk,
  input wire srst,
  input wire level,
  output wire rise,
  output wire fall
);

  reg prev;

  // Previous sample of the level
  always @(posedge ref_clk)
  begin
    if (srst)
      prev <= 1'b0;
    else
      prev <= level;
  end

  // One-cycle pulses on a change between cycles
  assign rise = level & ~prev;
  assign fall = ~level & prev;

endmodule

// ### core/cmp_output_event.v
`timescale 1ns/1ps
`include "cmp_event_defs.vh"

// Function
// - Enabled: result high when plus exceeds minus
// - Disabled: result forced low
// - Result synchronised to system clock
// - Latched result readable, interrupt source, pin
// - Raw unsynchronised result for wake, reset, pin
// - Separate rising and falling edge flags
// - Flags set regardless of interrupt enables
// - Flags stay set until software clears
// - Separate rise and fall interrupt enables
// - Processor request needs source and global enable; irq needs neither
// - Four response time settings selectable
// - Disabled comparator enters shutdown state
module cmp_output_event
(
  input wire ref_clk,
  input wire srst,
  input wire cmp_analog,
  input wire global_int_en,
  input wire [`CMP_ADDR_W-1:0] reg_addr,
  input wire [`CMP_DATA_W-1:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [`CMP_DATA_W-1:0] reg_rdata,
  output wire cmp_raw_out,
  output wire cmp_latched_out,
  output reg cmp_shutdown,
  output reg [1:0] cmp_resp_mode,
  output reg cmp_int_req,
  output reg irq
);

  // Control and mode state
  reg cmp_enable;
  reg rise_edge_flag;
  reg fall_edge_flag;
  reg rise_int_enable;
  reg fall_int_enable;
  reg [1:0] mode_sel;
  reg src_enable;
  reg [`CMP_EVT_NUM-1:0] evt_status;
  reg [`CMP_EVT_NUM-1:0] evt_mask;

  wire sync_result;
  wire rise_pulse;
  wire fall_pulse;
  wire [`CMP_EVT_NUM-1:0] evt_pulse;
  wire wr_ctrl;
  wire wr_mode;
  wire wr_src;
  wire wr_mask;
  wire rd_status;
  reg [`CMP_DATA_W-1:0] next_rdata;
  reg next_int_req;
  reg next_enable;
  reg next_rise_flag;
  reg next_fall_flag;
  reg next_rise_ie;
  reg next_fall_ie;
  reg [1:0] next_mode_sel;
  reg next_src_enable;
  reg [`CMP_EVT_NUM-1:0] next_evt_mask;
  reg [`CMP_EVT_NUM-1:0] next_evt_status;
  reg next_shutdown;
  reg [1:0] next_resp_mode;
  reg next_irq;
  wire clr_rise;
  wire clr_fall;
  reg [`CMP_DATA_W-1:0] ctrl_word;
  reg [`CMP_DATA_W-1:0] mode_word;
  reg [`CMP_DATA_W-1:0] src_word;
  reg [`CMP_DATA_W-1:0] status_word;
  reg [`CMP_DATA_W-1:0] mask_word;

  // Address match for a strobe
  function hit;
    input [`CMP_ADDR_W-1:0] addr;
    input [`CMP_ADDR_W-1:0] ofs;
    input strobe;
    begin
      hit = strobe & (addr == ofs);
    end
  endfunction

  assign wr_ctrl = hit(reg_addr, `CMP_OFS_CTRL, reg_wr);
  assign wr_mode = hit(reg_addr, `CMP_OFS_MODE, reg_wr);
  assign wr_src = hit(reg_addr, `CMP_OFS_SRC, reg_wr);
  assign wr_mask = hit(reg_addr, `CMP_OFS_EVT_MASK, reg_wr);
  assign rd_status = hit(reg_addr, `CMP_OFS_EVT_STATUS, reg_rd);

  // Raw result gated by enable; works without the clock
  assign cmp_raw_out = cmp_enable & cmp_analog;

  // Latched result for all clocked consumers
  cmp_sync2 u_sync
  (
    .ref_clk(ref_clk),
    .srst(srst),
    .async_in(cmp_raw_out),
    .sync_out(sync_result)
  );

  assign cmp_latched_out = sync_result;

  // Edge pulses from the latched result
  cmp_edge_detect u_edge
  (
    .ref_clk(ref_clk),
    .srst(srst),
    .level(sync_result),
    .rise(rise_pulse),
    .fall(fall_pulse)
  );

  assign evt_pulse = {fall_pulse, rise_pulse};

  // Flag clears: a written zero acknowledges the edge
  assign clr_rise = wr_ctrl & ~reg_wdata[`CMP_CTRL_RISE_FLAG];
  assign clr_fall = wr_ctrl & ~reg_wdata[`CMP_CTRL_FALL_FLAG];

  // Next control state; an edge beats a clearing write
  always @*
  begin
    next_enable = cmp_enable;
    next_rise_flag = rise_edge_flag;
    next_fall_flag = fall_edge_flag;
    if (wr_ctrl)
      next_enable = reg_wdata[`CMP_CTRL_ENABLE];
    if (rise_pulse)
      next_rise_flag = 1'b1;
    else if (clr_rise)
      next_rise_flag = 1'b0;
    if (fall_pulse)
      next_fall_flag = 1'b1;
    else if (clr_fall)
      next_fall_flag = 1'b0;
  end

  // Control register: enable and sticky edge flags
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      cmp_enable <= `CMP_RST_ENABLE;
      rise_edge_flag <= `CMP_RST_FLAG;
      fall_edge_flag <= `CMP_RST_FLAG;
    end
    else
    begin
      cmp_enable <= next_enable;
      rise_edge_flag <= next_rise_flag;
      fall_edge_flag <= next_fall_flag;
    end
  end

  // Next mode state, loaded by a mode write
  always @*
  begin
    next_rise_ie = rise_int_enable;
    next_fall_ie = fall_int_enable;
    next_mode_sel = mode_sel;
    if (wr_mode)
    begin
      next_rise_ie = reg_wdata[`CMP_MODE_RISE_IE];
      next_fall_ie = reg_wdata[`CMP_MODE_FALL_IE];
      next_mode_sel = reg_wdata[`CMP_MODE_SEL_HI:`CMP_MODE_SEL_LO];
    end
  end

  // Mode register: interrupt enables and response time
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      rise_int_enable <= `CMP_RST_RISE_IE;
      fall_int_enable <= `CMP_RST_FALL_IE;
      mode_sel <= `CMP_RST_MODE;
    end
    else
    begin
      rise_int_enable <= next_rise_ie;
      fall_int_enable <= next_fall_ie;
      mode_sel <= next_mode_sel;
    end
  end

  // Next source enable and event mask
  always @*
  begin
    next_src_enable = src_enable;
    next_evt_mask = evt_mask;
    if (wr_src)
      next_src_enable = reg_wdata[`CMP_SRC_ENABLE];
    if (wr_mask)
      next_evt_mask = reg_wdata[`CMP_EVT_NUM-1:0];
  end

  // Interrupt source enable and event mask
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      src_enable <= `CMP_RST_SRC;
      evt_mask <= `CMP_RST_EVT_MASK;
    end
    else
    begin
      src_enable <= next_src_enable;
      evt_mask <= next_evt_mask;
    end
  end

  // Sticky event status, cleared by a read; set wins
  genvar i;
  generate
    for (i = 0; i < `CMP_EVT_NUM; i = i + 1)
    begin : g_evt
      // Next status bit of one event
      always @*
      begin
        if (evt_pulse[i])
          next_evt_status[i] = 1'b1;
        else if (rd_status)
          next_evt_status[i] = 1'b0;
        else
          next_evt_status[i] = evt_status[i];
      end

      // Status bit register
      always @(posedge ref_clk)
      begin
        if (srst)
          evt_status[i] <= `CMP_RST_FLAG;
        else
          evt_status[i] <= next_evt_status[i];
      end
    end
  endgenerate

  // Processor request from enabled flags
  always @*
  begin
    next_int_req = ((rise_edge_flag & rise_int_enable) |
                    (fall_edge_flag & fall_int_enable)) &
                   src_enable & global_int_en;
  end

  // Next analog-side controls and level interrupt
  always @*
  begin
    next_shutdown = ~cmp_enable;
    next_resp_mode = mode_sel;
    next_irq = |(evt_status & evt_mask);
  end

  // Analog-side controls and interrupt outputs
  always @(posedge ref_clk)
  begin
    if (srst)
    begin
      cmp_shutdown <= `CMP_RST_SHUTDOWN;
      cmp_resp_mode <= `CMP_RST_MODE;
      cmp_int_req <= `CMP_RST_INT;
      irq <= `CMP_RST_INT;
    end
    else
    begin
      cmp_shutdown <= next_shutdown;
      cmp_resp_mode <= next_resp_mode;
      cmp_int_req <= next_int_req;
      irq <= next_irq;
    end
  end

  // Control word; the result bit is read-only
  always @*
  begin
    ctrl_word = `CMP_RST_RDATA;
    ctrl_word[`CMP_CTRL_ENABLE] = cmp_enable;
    ctrl_word[`CMP_CTRL_RESULT] = sync_result;
    ctrl_word[`CMP_CTRL_RISE_FLAG] = rise_edge_flag;
    ctrl_word[`CMP_CTRL_FALL_FLAG] = fall_edge_flag;
  end

  // Mode word
  always @*
  begin
    mode_word = `CMP_RST_RDATA;
    mode_word[`CMP_MODE_RISE_IE] = rise_int_enable;
    mode_word[`CMP_MODE_FALL_IE] = fall_int_enable;
    mode_word[`CMP_MODE_SEL_HI:`CMP_MODE_SEL_LO] = mode_sel;
  end

  // Source word
  always @*
  begin
    src_word = `CMP_RST_RDATA;
    src_word[`CMP_SRC_ENABLE] = src_enable;
  end

  // Event status and mask words
  always @*
  begin
    status_word = `CMP_RST_RDATA;
    status_word[`CMP_EVT_NUM-1:0] = evt_status;
    mask_word = `CMP_RST_RDATA;
    mask_word[`CMP_EVT_NUM-1:0] = evt_mask;
  end

  // Read data mux; unmapped offsets read zero
  always @*
  begin
    next_rdata = `CMP_RST_RDATA;
    case (reg_addr)
      `CMP_OFS_CTRL:
        next_rdata = ctrl_word;
      `CMP_OFS_MODE:
        next_rdata = mode_word;
      `CMP_OFS_SRC:
        next_rdata = src_word;
      `CMP_OFS_EVT_STATUS:
        next_rdata = status_word;
      `CMP_OFS_EVT_MASK:
        next_rdata = mask_word;
      default:
        next_rdata = `CMP_RST_RDATA;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always @(posedge ref_clk)
  begin
    if (srst)
      reg_rdata <= `CMP_RST_RDATA;
    else if (reg_rd)
      reg_rdata <= next_rdata;
    else
      reg_rdata <= `CMP_RST_RDATA;
  end

endmodule

// ### verification/irq_handler_model.sv
`timescale 1ns/1ps
module irq_handler_model
(
  input wire ref_clk,
  input wire srst,
  input wire gie_on,
  input wire cmp_int_req,
  output reg global_int_en = 1'b0,
  output reg [7:0] req_count = 8'h00
);
  // Global enable and tally of request cycles
  always @(posedge ref_clk)
  begin
    global_int_en <= gie_on & ~srst;
    req_count <= srst ? 8'h00 : req_count + {7'h00, cmp_int_req};
  end
endmodule

// ### verification/cmp_output_event_properties.sv
`timescale 1ns/1ps
`include "cmp_event_defs.vh"
module cmp_output_event_properties
(
  input wire ref_clk,
  input wire srst,
  input wire global_int_en,
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_rdata,
  input wire cmp_raw_out,
  input wire cmp_latched_out,
  input wire cmp_shutdown,
  input wire [1:0] cmp_resp_mode,
  input wire cmp_int_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // Control and mode writes
  wire ctrl_wr = reg_wr && reg_addr == `CMP_OFS_CTRL;
  wire mode_wr = reg_wr && reg_addr == `CMP_OFS_MODE;
  sequence s_off;
    cmp_shutdown [*3];
  endsequence
  property p_sync; cmp_latched_out == $past(cmp_raw_out, 2); endproperty
  property p_gie; cmp_int_req |-> $past(global_int_en); endproperty
  property p_rdz; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  property p_mode; mode_wr |-> ##2 cmp_resp_mode == $past(reg_wdata[1:0], 2); endproperty
  property p_dis; ctrl_wr && !reg_wdata[7] |-> ##2 cmp_shutdown; endproperty
  property p_en; ctrl_wr && reg_wdata[7] |-> ##2 !cmp_shutdown; endproperty
  property p_raw; ctrl_wr && !reg_wdata[7] |=> !cmp_raw_out; endproperty
  property p_lat; s_off |-> !cmp_latched_out; endproperty
  a_sync: assert property (p_sync) else $error("latched lag wrong");
  a_gie: assert property (p_gie) else $error("request without global");
  a_rdz: assert property (p_rdz) else $error("read data stands");
  a_mode: assert property (p_mode) else $error("mode not applied");
  a_dis: assert property (p_dis) else $error("no shutdown");
  a_en: assert property (p_en) else $error("shutdown stuck");
  a_raw: assert property (p_raw) else $error("raw not forced low");
  a_lat: assert property (p_lat) else $error("latched high while off");
endmodule

// ### verification/cmp_output_event_bench.sv
`timescale 1ns/1ps
module cmp_output_event_bench;
  reg ref_clk = 1'b0;
  reg srst = 1'b1;
  reg cmp_analog = 1'b0;
  reg gie_on = 1'b0;
  reg reg_wr = 1'b0;
  reg reg_rd = 1'b0;
  reg [3:0] reg_addr = 4'h0;
  reg [7:0] reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire [7:0] req_count;
  wire [1:0] cmp_resp_mode;
  wire cmp_raw_out, cmp_latched_out, cmp_shutdown, cmp_int_req, irq, global_int_en;
  integer failures = 0;
  integer checks = 0;
  integer i;
  // Clock and units
  always #12.5 ref_clk = ~ref_clk;
  cmp_output_event uut (.ref_clk, .srst, .cmp_analog, .global_int_en, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmp_raw_out, .cmp_latched_out,
    .cmp_shutdown, .cmp_resp_mode, .cmp_int_req, .irq);
  irq_handler_model host (.ref_clk, .srst, .gie_on, .cmp_int_req, .global_int_en,
    .req_count);
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp)
      begin
        failures = failures + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    begin
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  task rd(input [3:0] a, input [7:0] exp);
    begin
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
      @(posedge ref_clk);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Watchdog
  initial
  begin
    #50000;
    failures = failures + 1;
    finish_test;
  end
  // Tests
  initial
  begin
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    @(posedge ref_clk);
    for (i = 0; i < 6; i = i + 1)
      rd(i[3:0], 8'h00);
    chk({7'h00, cmp_shutdown}, 8'h01);
    $display("reset test done");
    wr(4'h0, 8'h80);
    cmp_analog <= 1'b1;
    #1 chk({7'h00, cmp_raw_out}, 8'h01);
    repeat (4) @(posedge ref_clk);
    rd(4'h0, 8'he0);
    chk({6'h00, cmp_int_req, irq}, 8'h00);
    rd(4'h3, 8'h01);
    rd(4'h3, 8'h00);
    wr(4'h1, 8'h20);
    wr(4'h2, 8'h01);
    chk({7'h00, cmp_int_req}, 8'h00);
    gie_on <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({7'h00, cmp_int_req}, 8'h01);
    wr(4'h0, 8'ha0);
    rd(4'h0, 8'he0);
    wr(4'h0, 8'h80);
    rd(4'h0, 8'hc0);
    chk({7'h00, cmp_int_req}, 8'h00);
    chk({7'h00, req_count != 8'h00}, 8'h01);
    $display("rise test done");
    wr(4'h4, 8'h02);
    wr(4'h1, 8'h10);
    cmp_analog <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk({6'h00, cmp_int_req, irq}, 8'h03);
    rd(4'h0, 8'h90);
    rd(4'h3, 8'h02);
    repeat (2) @(posedge ref_clk);
    chk({7'h00, irq}, 8'h00);
    $display("fall test done");
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(4'h1, i[7:0]);
      #1 chk({6'h00, cmp_resp_mode}, i[7:0]);
    end
    wr(4'h0, 8'h80);
    cmp_analog <= 1'b1;
    repeat (4) @(posedge ref_clk);
    wr(4'h0, 8'h30);
    #1 chk({7'h00, cmp_raw_out}, 8'h00);
    repeat (4) @(posedge ref_clk);
    rd(4'h0, 8'h30);
    chk({7'h00, cmp_shutdown}, 8'h01);
    $display("mode and disable test done");
    // Rising edge lands on the same edge as a clearing write
    wr(4'h0, 8'h80);
    @(posedge ref_clk);
    wr(4'h0, 8'h80);
    rd(4'h0, 8'he0);
    $display("same cycle test done");
    finish_test;
  end
endmodule
bind cmp_output_event cmp_output_event_properties props (.ref_clk, .srst, .global_int_en,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmp_raw_out, .cmp_latched_out,
  .cmp_shutdown, .cmp_resp_mode, .cmp_int_req);
